// *** io_pin_pkg.sv ***
// Constants for the I/O pin control and interrupt routing block.
// Assumes a 16-bit register port and a 100 MHz master clock.
package io_pin_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0]  IO_PIN_CONTROL_ADDR = 4'h3;   // Register index
  localparam logic [15:0] IO_PIN_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] IO_PIN_CONTROL_MASK = 16'h07ff; // Bits 15..11 read zero
  localparam logic [3:0]  MISC_CTRL_ADDR      = 4'h4;   // Standby enable and FIFO enable
  localparam logic [3:0]  PIN_STATUS_ADDR     = 4'h5;   // Read-only pin levels
  localparam logic [15:0] MISC_CTRL_MASK      = 16'h0003;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int OUT_SELECT_LSB  = 0;   // aux_pinN_output_select at 0..3
  localparam int OUT_LEVEL_LSB   = 4;   // aux_pinN_out_level at 4..7
  localparam int INT_PIN_SEL_LSB = 8;   // Two-bit routing field
  localparam int SYNC_CLEAR_BIT  = 10;
  localparam int STBY_EN_BIT     = 0;   // In MISC_CTRL
  localparam int FIFO_EN_BIT     = 1;   // In MISC_CTRL
  localparam int NUM_AUX         = 4;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] INT_TO_INT_PIN = 2'h0;
  localparam logic [1:0] INT_TO_CLK_PIN = 2'h1;
  localparam logic [1:0] INT_TO_AUX2    = 2'h2;
  localparam logic [1:0] INT_TO_DOUT    = 2'h3;
  localparam logic [1:0] MCLK_INT_OUT   = 2'h1;

endpackage : io_pin_pkg

// *** sync_edge_if.sv ***
// Carrier between the top and the sync-pin edge detector.
// Assumes both ends share i_mclk.
`timescale 1ns/1ps
`default_nettype none
interface sync_edge_if;
  logic pin_n;      // Raw sync pin level
  logic fall_pulse; // One-cycle falling-edge event
  modport detector (input pin_n, output fall_pulse);
  modport user     (output pin_n, input fall_pulse);
endinterface : sync_edge_if
`default_nettype wire

// *** sync_fall_detect.sv ***
// Synchroniser and falling-edge detector for the sync pin.
// Assumes the pin is asynchronous to i_mclk.
`timescale 1ns/1ps
`default_nettype none
module sync_fall_detect (
  input wire logic     i_mclk,
  input wire logic     i_rst_n,
  sync_edge_if.detector sif
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Two stages; pin idles high so reset to 1 avoids a false edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= sif.pin_n;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // High to low transition marks the pulse
  assign sif.fall_pulse = prev_r & ~sync_r;
endmodule : sync_fall_detect
`default_nettype wire

// *** io_pin_ctrl.sv ***
// I/O pin control and interrupt routing for a low-power converter.
// Assumes interrupt sources and clock outputs come from same-clock logic.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - With sync clear enabled, a sync pulse empties the FIFO; otherwise none.
// - Routed event is data-ready with FIFO off, FIFO interrupt with FIFO on.
// - Routing 00 drives the event onto the interrupt pin.
// - Routing 01 drives the event onto the clock pin, over clock output.
// - Routing 10 drives the event onto aux pin 2, over its output select.
// - Routing 11 drives only data-ready onto the serial data output while i_dout_oe is low.
// - Each aux pin level follows its level bit when selected as output, unless standby or routing 10 takes that pin.
// - Output select 0 keeps the input function, 1 makes a general output.
// - Aux pins 1 to 4 are analog inputs 2 to 5, each bit acting on its pin.
// - Standby indicator enable makes aux pin 4 the standby output, top priority.
// - Interrupt routed to aux pin 2 takes top priority on that pin.
// - Clock select 01 presents the internal oscillator on the clock pin unless routing is 01.
module io_pin_ctrl import io_pin_pkg::*; (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Event sources from the converter core
  input  wire logic        i_data_ready,
  input  wire logic        i_fifo_irq,
  input  wire logic        i_standby_level,
  input  wire logic [1:0]  i_mclk_sel,
  input  wire logic        i_int_osc_clk,
  input  wire logic        i_dout_data,
  input  wire logic        i_dout_oe,
  // Pins
  input  wire logic        i_sync_n,
  output logic             o_fifo_clear,
  output logic             o_int_pin,
  output logic             o_clk_pin,
  output logic             o_clk_pin_oe,
  output logic             o_dout_pin,
  output logic             o_dout_pin_oe,
  input  wire logic [3:0]  i_aux_pin,
  output logic      [3:0]  o_aux_pin,
  output logic      [3:0]  o_aux_pin_oe,
  output logic      [3:0]  o_aux_input_enable
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] io_pin_control_r;
  logic [15:0] misc_ctrl_r;
  logic [15:0] rdata_r;
  logic [3:0]  aux_meta_r;
  logic [3:0]  aux_sync_r;

  logic [3:0]  aux_pin_output_select;
  logic [3:0]  aux_pin_out_level;
  logic [1:0]  int_pin_sel;
  logic        sync_fifo_clear_enable;
  logic        standby_indicator_enable;
  logic        fifo_enable;
  logic        routed_event;
  logic        sync_fall;

  sync_edge_if sif ();

  assign aux_pin_output_select    = io_pin_control_r[OUT_SELECT_LSB +: NUM_AUX];
  assign aux_pin_out_level        = io_pin_control_r[OUT_LEVEL_LSB +: NUM_AUX];
  assign int_pin_sel              = io_pin_control_r[INT_PIN_SEL_LSB +: 2];
  assign sync_fifo_clear_enable   = io_pin_control_r[SYNC_CLEAR_BIT];
  assign standby_indicator_enable = misc_ctrl_r[STBY_EN_BIT];
  assign fifo_enable              = misc_ctrl_r[FIFO_EN_BIT];

  // Control register write; reserved bits masked so they stay zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      io_pin_control_r <= IO_PIN_CONTROL_RST;
    end else if (i_wr && i_addr == IO_PIN_CONTROL_ADDR) begin
      io_pin_control_r <= i_wdata & IO_PIN_CONTROL_MASK;
    end
  end

  // Standby and FIFO enables held in a local register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      misc_ctrl_r <= 16'h0000;
    end else if (i_wr && i_addr == MISC_CTRL_ADDR) begin
      misc_ctrl_r <= i_wdata & MISC_CTRL_MASK;
    end
  end

  // Aux pin inputs cross from the pads through two stages
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_meta_r <= 4'h0;
      aux_sync_r <= 4'h0;
    end else begin
      aux_meta_r <= i_aux_pin;
      aux_sync_r <= aux_meta_r;
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        IO_PIN_CONTROL_ADDR: rdata_r <= io_pin_control_r;
        MISC_CTRL_ADDR:      rdata_r <= misc_ctrl_r;
        PIN_STATUS_ADDR:     rdata_r <= {12'h000, aux_sync_r};
        default:             rdata_r <= 16'h0000;
      endcase
    end
  end
  assign o_rdata = rdata_r;

  // ****************************************************************
  // Sync pin and FIFO clear
  // ****************************************************************
  assign sif.pin_n = i_sync_n;
  assign sync_fall = sif.fall_pulse;

  sync_fall_detect u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .sif     (sif.detector)
  );

  // Registered so the clear pulse is glitch-free for the FIFO
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fifo_clear <= 1'b0;
    end else begin
      o_fifo_clear <= sync_fall & sync_fifo_clear_enable;
    end
  end

  // ****************************************************************
  // Interrupt routing
  // ****************************************************************
  assign routed_event = fifo_enable ? i_fifo_irq : i_data_ready;

  // Interrupt and clock pins
  always_comb begin
    o_int_pin    = 1'b0;
    o_clk_pin    = 1'b0;
    o_clk_pin_oe = 1'b0;
    case (int_pin_sel)
      INT_TO_INT_PIN: o_int_pin = routed_event;
      INT_TO_CLK_PIN: begin
        o_clk_pin    = routed_event;
        o_clk_pin_oe = 1'b1;
      end
      default: o_int_pin = 1'b0;
    endcase
    // Oscillator out only when routing leaves the clock pin alone
    if (int_pin_sel != INT_TO_CLK_PIN && i_mclk_sel == MCLK_INT_OUT) begin
      o_clk_pin    = i_int_osc_clk;
      o_clk_pin_oe = 1'b1;
    end
  end

  // Serial data pin doubles as data-ready; FIFO event never goes here
  always_comb begin
    if (int_pin_sel == INT_TO_DOUT && !i_dout_oe) begin
      o_dout_pin    = i_data_ready;
      o_dout_pin_oe = 1'b1;
    end else begin
      o_dout_pin    = i_dout_data;
      o_dout_pin_oe = i_dout_oe;
    end
  end

  // ****************************************************************
  // Aux pins, index n is aux pin n+1 on analog input n+2
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_AUX; gi++) begin : g_aux
      always_comb begin
        if (gi == 3 && standby_indicator_enable) begin
          o_aux_pin[gi]    = i_standby_level;
          o_aux_pin_oe[gi] = 1'b1;
        end else if (gi == 1 && int_pin_sel == INT_TO_AUX2) begin
          o_aux_pin[gi]    = routed_event;
          o_aux_pin_oe[gi] = 1'b1;
        end else if (aux_pin_output_select[gi]) begin
          o_aux_pin[gi]    = aux_pin_out_level[gi];
          o_aux_pin_oe[gi] = 1'b1;
        end else begin
          o_aux_pin[gi]    = 1'b0;
          o_aux_pin_oe[gi] = 1'b0;
        end
        o_aux_input_enable[gi] = ~o_aux_pin_oe[gi];
      end
    end
  endgenerate

endmodule : io_pin_ctrl
`default_nettype wire

// *** io_pin_ctrl_sva.sv ***
// Checker for the pin control block, bound to its top ports.
// Assumes one clock domain and the register map of io_pin_pkg.
`timescale 1ns/1ps
`default_nettype none
module io_pin_ctrl_sva import io_pin_pkg::*; (
  input wire logic        i_mclk, i_rst_n, i_wr, i_rd, i_data_ready, i_fifo_irq, i_standby_level,
  input wire logic        i_int_osc_clk, i_dout_oe, i_sync_n, o_fifo_clear, o_int_pin, o_clk_pin,
  input wire logic        o_clk_pin_oe, o_dout_pin,
  input wire logic [3:0]  i_addr, o_aux_pin, o_aux_pin_oe, o_aux_input_enable,
  input wire logic [1:0]  i_mclk_sel,
  input wire logic [15:0] i_wdata, o_rdata
);
  // ****
  // Register shadows
  // ****
  logic [15:0] ctrl_r;
  logic [1:0]  misc_r;
  logic        ev;
  logic [1:0]  sel;
  // Shadow copies let pin checks follow software state
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) ctrl_r <= '0;
    else if (i_wr && i_addr == IO_PIN_CONTROL_ADDR) ctrl_r <= i_wdata & IO_PIN_CONTROL_MASK;
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) misc_r <= '0;
    else if (i_wr && i_addr == MISC_CTRL_ADDR) misc_r <= i_wdata[1:0];
  end
  assign ev  = misc_r[FIFO_EN_BIT] ? i_fifo_irq : i_data_ready;
  assign sel = ctrl_r[9:8];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ****
  // Properties
  // ****
  property p_int; sel == 2'h0 |-> o_int_pin == ev; endproperty
  a_int: assert property (p_int) else $error("int pin wrong");
  property p_clk; sel == 2'h1 |-> o_clk_pin_oe && o_clk_pin == ev; endproperty
  a_clk: assert property (p_clk) else $error("clk pin event wrong");
  property p_osc; sel != 2'h1 && i_mclk_sel == MCLK_INT_OUT |-> o_clk_pin_oe && o_clk_pin == i_int_osc_clk; endproperty
  a_osc: assert property (p_osc) else $error("clk pin osc wrong");
  property p_aux2; sel == 2'h2 |-> o_aux_pin_oe[1] && o_aux_pin[1] == ev; endproperty
  a_aux2: assert property (p_aux2) else $error("aux2 event wrong");
  property p_dout; sel == 2'h3 && !i_dout_oe |-> o_dout_pin == i_data_ready; endproperty
  a_dout: assert property (p_dout) else $error("dout event wrong");
  property p_stby; misc_r[STBY_EN_BIT] |-> o_aux_pin_oe[3] && o_aux_pin[3] == i_standby_level; endproperty
  a_stby: assert property (p_stby) else $error("standby pin wrong");
  property p_gpo; o_aux_pin_oe[0] == ctrl_r[0] && (!ctrl_r[0] || o_aux_pin[0] == ctrl_r[4]); endproperty
  a_gpo: assert property (p_gpo) else $error("aux1 output wrong");
  property p_rd; i_rd && i_addr == IO_PIN_CONTROL_ADDR |=> o_rdata == ctrl_r; endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
  property p_clr; $fell(i_sync_n) && ctrl_r[SYNC_CLEAR_BIT] |-> ##[3:5] o_fifo_clear; endproperty
  a_clr: assert property (p_clr) else $error("no fifo clear");
  property p_one; o_fifo_clear |=> !o_fifo_clear; endproperty
  a_one: assert property (p_one) else $error("clear pulse too long");
endmodule : io_pin_ctrl_sva
bind io_pin_ctrl io_pin_ctrl_sva u_sva (.*);
`default_nettype wire

// *** pin_partner.sv ***
// Model of the board around the pins: sync driver and aux pads.
// Assumes the bench asks for sync pulses with a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic       i_mclk,
  input  wire logic       sync_go,
  input  wire logic [3:0] o_aux_pin,
  input  wire logic [3:0] o_aux_pin_oe,
  output logic            i_sync_n,
  output logic      [3:0] i_aux_pin
);
  logic [3:0] ext_r = 4'h5;
  int         low_cnt = 0;
  // Undriven pads toggle so a stale level never passes for a driven one
  always @(posedge i_mclk) begin
    ext_r <= ~ext_r;
    if (sync_go) low_cnt <= 4;
    else if (low_cnt > 0) low_cnt <= low_cnt - 1;
  end
  assign i_sync_n  = (low_cnt == 0);
  assign i_aux_pin = (o_aux_pin_oe & o_aux_pin) | (~o_aux_pin_oe & ext_r);
endmodule : pin_partner
`default_nettype wire

// *** io_pin_ctrl_tb.sv ***
// Self-checking bench for the pin control block.
// Assumes pin_partner and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module io_pin_ctrl_tb;
  import io_pin_pkg::*;
  logic i_mclk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_data_ready = 0, i_fifo_irq = 0, sync_go = 0;
  logic i_standby_level = 0, i_int_osc_clk = 0, i_dout_data = 0, i_dout_oe = 0, rd_d = 0, ev;
  logic o_fifo_clear, o_int_pin, o_clk_pin, o_clk_pin_oe, o_dout_pin, o_dout_pin_oe;
  logic [3:0] i_addr = 0, o_aux_pin, o_aux_pin_oe, o_aux_input_enable;
  logic [1:0] i_mclk_sel = 0;
  logic [15:0] i_wdata = 0, o_rdata, e, v;
  wire i_sync_n;
  wire [3:0] i_aux_pin;
  logic [15:0] exp_q[$];
  int n_mismatch = 0, cmp_count = 0, n_clr = 0, cyc = 0, k;
  integer seed = 32'h25ab;
  io_pin_ctrl u_dut (.*);
  pin_partner u_pp (.*);
  initial forever #5 i_mclk = ~i_mclk;
  // ****
  // Bus tasks: wr, rd and idle each drive once, just after a rising edge
  // ****
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a; i_wdata <= d; i_wr <= 1; i_rd <= 0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a; i_rd <= 1; i_wr <= 0;
    exp_q.push_back(d);
  endtask : rd
  task automatic idle;
    @(posedge i_mclk);
    i_wr <= 0; i_rd <= 0;
  endtask : idle
  task automatic pulse;
    n_clr = 0;
    @(posedge i_mclk);
    sync_go <= 1;
    @(posedge i_mclk);
    sync_go <= 0;
    repeat (12) @(posedge i_mclk);
  endtask : pulse
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Read data is checked the cycle after the strobe; it holds until the next read
  always @(posedge i_mclk) begin
    rd_d <= i_rd;
    if (o_fifo_clear) n_clr++;
    cyc++;
    if (cyc == 3000) begin n_mismatch++; wrap_up; end
  end
  always @(negedge i_mclk) if (rd_d) begin e = exp_q.pop_front(); `CHK(o_rdata, e) end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1;
    rd(IO_PIN_CONTROL_ADDR, 16'h0000); rd(MISC_CTRL_ADDR, 16'h0000);
    wr(IO_PIN_CONTROL_ADDR, 16'hffff); wr(4'hf, 16'h1234);
    rd(IO_PIN_CONTROL_ADDR, 16'h07ff); rd(4'hf, 16'h0000);
    for (k = 0; k < 8; k++) begin
      v = $random(seed);
      wr(IO_PIN_CONTROL_ADDR, {8'h00, v[7:0]}); idle; @(negedge i_mclk);
      `CHK(o_aux_pin_oe, v[3:0])
      `CHK(o_aux_pin & v[3:0], v[7:4] & v[3:0])
      `CHK(o_aux_input_enable, ~v[3:0])
    end
    wr(IO_PIN_CONTROL_ADDR, 16'h00af); idle; idle; idle; rd(PIN_STATUS_ADDR, 16'h000a);
    for (k = 0; k < 16; k++) begin
      wr(MISC_CTRL_ADDR, {14'h0, k[2], 1'b0}); wr(IO_PIN_CONTROL_ADDR, {6'h0, k[1:0], 8'h22});
      @(posedge i_mclk); v = $random(seed);
      i_wr <= 0; i_mclk_sel <= MCLK_INT_OUT; i_data_ready <= v[0]; i_fifo_irq <= v[1]; i_int_osc_clk <= v[2];
      @(negedge i_mclk); ev = k[2] ? i_fifo_irq : i_data_ready;
      case (k[1:0])
        2'h0: begin `CHK(o_int_pin, ev) `CHK({o_clk_pin_oe, o_clk_pin}, {1'b1, i_int_osc_clk}) end
        2'h1: `CHK({o_clk_pin_oe, o_clk_pin}, {1'b1, ev})
        2'h2: `CHK({o_aux_pin_oe[1], o_aux_pin[1]}, {1'b1, ev})
        default: `CHK({o_dout_pin_oe, o_dout_pin}, {1'b1, i_data_ready})
      endcase
    end
    wr(MISC_CTRL_ADDR, 16'h0001); wr(IO_PIN_CONTROL_ADDR, 16'h0088); idle; @(negedge i_mclk);
    `CHK({o_aux_pin_oe[3], o_aux_pin[3]}, 2'b10)
    wr(MISC_CTRL_ADDR, 16'h0000); wr(IO_PIN_CONTROL_ADDR, 16'h0400); idle; pulse;
    `CHK(n_clr, 1)
    wr(IO_PIN_CONTROL_ADDR, 16'h0000); idle; pulse;
    `CHK(n_clr, 0)
    wrap_up;
  end
endmodule : io_pin_ctrl_tb
`default_nettype wire
